// file: verilog/aiu_pkg.sv
// package: register map, field layout and timing constants of the audio input port
package aiu_pkg;
  // register byte offsets
  localparam logic [7:0] AIU_CFG_OFS    = 8'h00;
  localparam logic [7:0] AIU_OSC_OFS    = 8'h04;
  localparam logic [7:0] AIU_DIV_OFS    = 8'h08;
  localparam logic [7:0] AIU_HALF_OFS   = 8'h0c;
  localparam logic [7:0] AIU_STAT_OFS   = 8'h10;
  localparam logic [7:0] AIU_LEFT_OFS   = 8'h14;
  localparam logic [7:0] AIU_RIGHT_OFS  = 8'h18;
  localparam int         AIU_ADDR_W     = 8;
  // config field positions
  localparam int         AIU_CFG_MASTER = 0;
  localparam int         AIU_CFG_RISE   = 1;
  localparam int         AIU_CFG_EN     = 2;
  // reset values and clamp minimums
  localparam logic [2:0]  AIU_CFG_RST   = 3'h6;
  localparam logic [31:0] AIU_OSC_RST   = 32'h0000_0000;
  localparam logic [7:0]  AIU_DIV_RST   = 8'h08;
  localparam logic [5:0]  AIU_HALF_RST  = 6'h20;
  localparam logic [7:0]  AIU_DIV_MIN   = 8'h02;
  localparam logic [5:0]  AIU_HALF_MIN  = 6'h01;
  // axi responses
  localparam logic [1:0]  AIU_RESP_OK   = 2'h0;
  localparam logic [1:0]  AIU_RESP_ERR  = 2'h2;
  // timing: main clock, bit clock ceiling and oscillator ceiling
  localparam int          AIU_CLK_HZ    = 40_000_000;
  localparam int          AIU_SCK_MAX_HZ = 22_000_000;
  localparam int          AIU_OSC_MAX_HZ = 40_000_000;
  // least main-clock cycles per bit clock period, rounded up
  localparam int          AIU_SCK_MIN_CYC = (AIU_CLK_HZ + AIU_SCK_MAX_HZ - 1) / AIU_SCK_MAX_HZ;

  // software configuration as seen by the serial logic
  typedef struct packed {
    logic        master;
    logic        rise;
    logic        enable;
    logic [31:0] osc_step;
    logic [7:0]  sck_div;
    logic [5:0]  half_bits;
  } aiu_cfg_type;

  // one received stereo frame
  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } aiu_frame_type;

  // bit clock role
  typedef enum logic [0:0] {AIU_ROLE_SLAVE = 1'b0, AIU_ROLE_MASTER = 1'b1} aiu_role_type;
endpackage

// file: verilog/aiu_rx.sv
// audio input serial receiver with axi4-lite register slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module aiu_rx
  import aiu_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite slave
  input  wire logic [AIU_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AIU_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // converter pins
  output logic                       oversample_clock_out,
  input  wire logic                  serial_bit_clock_i,
  output logic                       serial_bit_clock_o,
  output logic                       serial_bit_clock_oe,
  input  wire logic                  serial_data_in,
  input  wire logic                  word_select_line_i,
  output logic                       word_select_line_o,
  output logic                       word_select_line_oe,
  // received samples
  output aiu_frame_type              frame_out,
  output logic                       frame_valid
);

  // byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  // true for an offset that maps a register; status and sample registers count for reads only
  function automatic logic reg_hit(input logic [AIU_ADDR_W-1:0] a, input logic wr);
    logic ok;
    ok = (a == AIU_CFG_OFS) || (a == AIU_OSC_OFS) || (a == AIU_DIV_OFS) || (a == AIU_HALF_OFS);
    if (!wr)
      ok = ok || (a == AIU_STAT_OFS) || (a == AIU_LEFT_OFS) || (a == AIU_RIGHT_OFS);
    return ok;
  endfunction

  aiu_cfg_type           cfg_r;
  aiu_role_type          role;
  logic [AIU_ADDR_W-1:0] aw_addr_r;
  logic                  aw_have_r;
  logic [31:0]           w_data_r;
  logic [3:0]            w_strb_r;
  logic                  w_have_r;
  logic                  do_write;
  logic [31:0]           cfg_word;
  logic [31:0]           cfg_merge;
  logic [31:0]           osc_merge;
  logic [31:0]           div_merge;
  logic [31:0]           half_merge;
  logic [31:0]           osc_acc_r;
  logic                  osc_prev_r;
  logic                  osc_tick;
  logic [7:0]            div_eff;
  logic [5:0]            half_eff;
  logic [7:0]            div_cnt_r;
  logic                  sck_out_r;
  logic                  sck_src;
  logic [2:0]            sck_sync_r;
  logic [2:0]            sd_sync_r;
  logic [2:0]            ws_sync_r;
  logic                  sck_lvl_r;
  logic                  sd_lvl_r;
  logic                  ws_lvl_r;
  logic                  rise_ev;
  logic                  fall_ev;
  logic                  samp_ev;
  logic                  sck_nxt;
  logic                  mst_drive;
  logic                  ws_src;
  logic                  ws_out_r;
  logic [5:0]            ws_cnt_r;
  logic                  ws_now;
  logic                  ws_prev_r;
  logic [31:0]           shift_r;
  logic [31:0]           left_r;
  logic [15:0]           frame_cnt_r;

  assign role     = aiu_role_type'(cfg_r.master);
  assign cfg_word = {29'h0, cfg_r.enable, cfg_r.rise, cfg_r.master};

  // merged write words; a select on a call result is not portable, so they are named
  assign cfg_merge  = lane_merge(cfg_word, w_data_r, w_strb_r);
  assign osc_merge  = lane_merge(cfg_r.osc_step, w_data_r, w_strb_r);
  assign div_merge  = lane_merge({24'h0, cfg_r.sck_div}, w_data_r, w_strb_r);
  assign half_merge = lane_merge({26'h0, cfg_r.half_bits}, w_data_r, w_strb_r);

  // write address and data are taken independently, in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign do_write      = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_r <= 1'b0;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AIU_RESP_OK;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_hit(aw_addr_r, 1'b1) ? AIU_RESP_OK : AIU_RESP_ERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // configuration registers; unmapped writes change nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_r.master    <= AIU_CFG_RST[AIU_CFG_MASTER];
      cfg_r.rise      <= AIU_CFG_RST[AIU_CFG_RISE];
      cfg_r.enable    <= AIU_CFG_RST[AIU_CFG_EN];
      cfg_r.osc_step  <= AIU_OSC_RST;
      cfg_r.sck_div   <= AIU_DIV_RST;
      cfg_r.half_bits <= AIU_HALF_RST;
    end
    else if (do_write)
    begin
      case (aw_addr_r)
        AIU_CFG_OFS:
        begin
          cfg_r.master <= cfg_merge[AIU_CFG_MASTER];
          cfg_r.rise   <= cfg_merge[AIU_CFG_RISE];
          cfg_r.enable <= cfg_merge[AIU_CFG_EN];
        end
        AIU_OSC_OFS:  cfg_r.osc_step  <= osc_merge;
        AIU_DIV_OFS:  cfg_r.sck_div   <= div_merge[7:0];
        AIU_HALF_OFS: cfg_r.half_bits <= half_merge[5:0];
        default:      cfg_r <= cfg_r;
      endcase
    end
  end

  // read channel: one read in flight, answered the cycle after acceptance
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AIU_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= reg_hit(s_axi_araddr, 1'b0) ? AIU_RESP_OK : AIU_RESP_ERR;
      case (s_axi_araddr)
        AIU_CFG_OFS:   s_axi_rdata <= cfg_word;
        AIU_OSC_OFS:   s_axi_rdata <= cfg_r.osc_step;
        AIU_DIV_OFS:   s_axi_rdata <= {24'h0, cfg_r.sck_div};
        AIU_HALF_OFS:  s_axi_rdata <= {26'h0, cfg_r.half_bits};
        AIU_STAT_OFS:  s_axi_rdata <= {13'h0, ws_lvl_r, sck_lvl_r, role, frame_cnt_r};
        AIU_LEFT_OFS:  s_axi_rdata <= frame_out.left;
        AIU_RIGHT_OFS: s_axi_rdata <= frame_out.right;
        default:       s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // phase accumulator: f = step * 40 MHz / 2^32; the msb toggle limits the
  // real output to 20 MHz, a trade against needing a faster clock or a pll
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_acc_r  <= 32'h0000_0000;
      osc_prev_r <= 1'b0;
    end
    else
    begin
      osc_acc_r  <= cfg_r.enable ? 32'(osc_acc_r + cfg_r.osc_step) : 32'h0000_0000;
      osc_prev_r <= osc_acc_r[31];
    end
  end

  assign oversample_clock_out = osc_acc_r[31];
  assign osc_tick             = osc_acc_r[31] && !osc_prev_r;

  // divisor below two cannot make a bit clock edge pair, so it is clamped
  assign div_eff  = (cfg_r.sck_div < AIU_DIV_MIN) ? AIU_DIV_MIN : cfg_r.sck_div;
  assign half_eff = (cfg_r.half_bits < AIU_HALF_MIN) ? AIU_HALF_MIN : cfg_r.half_bits;

  // next master clock level; word select moves on the edge that leaves the sampling level,
  // taken here at the source because the synchronised edge arrives too late
  assign sck_nxt   = (div_cnt_r >= div_eff - 8'h01) || (div_cnt_r < (div_eff >> 1) - 8'h01);
  assign mst_drive = (role == AIU_ROLE_MASTER) && cfg_r.enable && osc_tick &&
                     (sck_nxt != sck_out_r) && (sck_nxt != cfg_r.rise);

  // master bit clock: one period per div_eff oversample periods
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt_r <= 8'h00;
      sck_out_r <= 1'b0;
    end
    else if (role == AIU_ROLE_MASTER && cfg_r.enable && osc_tick)
    begin
      div_cnt_r <= (div_cnt_r >= div_eff - 8'h01) ? 8'h00 : div_cnt_r + 8'h01;
      sck_out_r <= sck_nxt;
    end
  end

  assign serial_bit_clock_o  = sck_out_r;
  assign serial_bit_clock_oe = (role == AIU_ROLE_MASTER);
  assign word_select_line_o  = ws_out_r;
  assign word_select_line_oe = (role == AIU_ROLE_MASTER);

  // driven clock and word select re-enter the same chains so data and edges stay aligned
  assign sck_src = (role == AIU_ROLE_MASTER) ? sck_out_r : serial_bit_clock_i;
  assign ws_src  = (role == AIU_ROLE_MASTER) ? ws_out_r : word_select_line_i;

  // three-stage synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_sync_r <= 3'h0;
      sd_sync_r  <= 3'h0;
      ws_sync_r  <= 3'h0;
    end
    else
    begin
      sck_sync_r <= {sck_sync_r[1:0], sck_src};
      sd_sync_r  <= {sd_sync_r[1:0], serial_data_in};
      ws_sync_r  <= {ws_sync_r[1:0], ws_src};
    end
  end

  // a level is accepted once stages one and two agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_lvl_r <= 1'b0;
      sd_lvl_r  <= 1'b0;
      ws_lvl_r  <= 1'b0;
    end
    else
    begin
      if (sck_sync_r[1] == sck_sync_r[2])
        sck_lvl_r <= sck_sync_r[2];
      if (sd_sync_r[1] == sd_sync_r[2])
        sd_lvl_r <= sd_sync_r[2];
      if (ws_sync_r[1] == ws_sync_r[2])
        ws_lvl_r <= ws_sync_r[2];
    end
  end

  assign rise_ev  = (sck_sync_r[1] == sck_sync_r[2]) && sck_sync_r[2] && !sck_lvl_r;
  assign fall_ev  = (sck_sync_r[1] == sck_sync_r[2]) && !sck_sync_r[2] && sck_lvl_r;
  assign samp_ev  = cfg_r.enable && (cfg_r.rise ? rise_ev : fall_ev);

  // master word select: toggles after half_eff bits, on the non-sampling edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ws_out_r <= 1'b0;
      ws_cnt_r <= 6'h00;
    end
    else if (mst_drive)
    begin
      if (ws_cnt_r >= half_eff - 6'h01)
      begin
        ws_cnt_r <= 6'h00;
        ws_out_r <= !ws_out_r;
      end
      else
        ws_cnt_r <= ws_cnt_r + 6'h01;
    end
  end

  // word select is taken from its synchroniser on the data sampling edge
  assign ws_now = ws_lvl_r;

  // assembly: any word length accepted, last 32 bits kept, msb first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ws_prev_r   <= 1'b0;
      shift_r     <= 32'h0000_0000;
      left_r      <= 32'h0000_0000;
      frame_out   <= '0;
      frame_valid <= 1'b0;
      frame_cnt_r <= 16'h0000;
    end
    else
    begin
      frame_valid <= 1'b0;
      if (samp_ev)
      begin
        ws_prev_r <= ws_now;
        if (ws_now != ws_prev_r)
        begin
          shift_r <= {31'h0, sd_lvl_r};
          if (!ws_prev_r)
            left_r <= shift_r;
          else
          begin
            frame_out   <= '{left: left_r, right: shift_r};
            frame_valid <= 1'b1;
            frame_cnt_r <= frame_cnt_r + 16'h0001;
          end
        end
        else
          shift_r <= {shift_r[30:0], sd_lvl_r};
      end
    end
  end

endmodule // aiu_rx
`default_nettype wire

// file: tb/aiu_rx_sva.sv
// checker: port-level assertions for the audio input receiver
`timescale 1ns/1ps
`default_nettype none
module aiu_rx_sva
  import aiu_pkg::*;
(
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          serial_bit_clock_o,
  input wire logic          serial_bit_clock_oe,
  input wire logic          word_select_line_o,
  input wire logic          word_select_line_oe,
  input wire aiu_frame_type frame_out,
  input wire logic          frame_valid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // reset is watched itself, so this one is never disabled
  reset_quiet_a: assert property (disable iff (1'b0)
    !aresetn |=> !frame_valid && !s_axi_bvalid && !serial_bit_clock_oe)
    else $error("outputs active after reset");
  pin_roles_a: assert property (serial_bit_clock_oe == word_select_line_oe)
    else $error("clock and word select roles differ");
  frame_pulse_a: assert property (frame_valid |=> !frame_valid)
    else $error("frame strobe longer than one cycle");
  frame_update_a: assert property ($changed(frame_out) |-> ##[0:1] frame_valid)
    else $error("frame changed without strobe");
  // each phase lasts at least two cycles, since oversample ticks are at least two cycles apart
  sck_high_a: assert property ($rose(serial_bit_clock_o) |=> serial_bit_clock_o)
    else $error("bit clock high phase too short");
  sck_low_a: assert property ($fell(serial_bit_clock_o) |=> !serial_bit_clock_o)
    else $error("bit clock low phase too short");
  // a driven word select may only move together with a bit clock edge
  ws_edge_a: assert property (word_select_line_oe && $changed(word_select_line_o)
    |-> $changed(serial_bit_clock_o))
    else $error("word select moved away from a bit clock edge");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  arready_link_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
endmodule // aiu_rx_sva
bind aiu_rx aiu_rx_sva aiu_rx_sva_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .serial_bit_clock_o(serial_bit_clock_o), .serial_bit_clock_oe(serial_bit_clock_oe),
  .word_select_line_o(word_select_line_o), .word_select_line_oe(word_select_line_oe),
  .frame_out(frame_out), .frame_valid(frame_valid));
`default_nettype wire

// file: tb/aiu_conv_model.sv
// converter model: own bit clock and word select in slave role, serial data always
`timescale 1ns/1ps
`default_nettype none
module aiu_conv_model (
  input  wire logic        sck_w,
  input  wire logic        rise,
  input  wire logic        run,
  input  var  int          half_ns,
  input  wire logic [31:0] left,
  input  wire logic [31:0] right,
  output logic             own_sck,
  output logic             own_ws,
  output logic             sd
);
  int nbit;
  initial
  begin
    own_sck = 1'b0;
    own_ws = 1'b0;
    nbit = 0;
  end
  // free of the main clock; the offset keeps a zero delay from hanging time zero
  always #(half_ns + 10) if (run) own_sck = ~own_sck;
  // word select and data move on the non-sampling edge of whoever drives the clock
  always @(sck_w)
    if (sck_w !== rise)
    begin
      if (nbit == 31) own_ws <= ~own_ws;
      nbit <= (nbit == 31) ? 0 : nbit + 1;
    end
  // msb first, left word while word select is low
  assign sd = own_ws ? right[31 - nbit] : left[31 - nbit];
endmodule // aiu_conv_model
`default_nettype wire

// file: tb/testbench.sv
// testbench: register table rows, then slave, falling-edge and master frames
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aiu_pkg::*;
  typedef struct packed { logic we; logic [7:0] a; logic [31:0] d; logic [1:0] r; } aiu_row_type;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, m_rise = 1'b1, m_run = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, m_left = 32'h0, m_right = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, osc, sck_o, sck_oe, ws_o, ws_oe, frame_valid;
  logic m_sck, m_ws, sd;
  aiu_frame_type frame_out;
  int m_half = 100, n_errors = 0, checked = 0;
  wire logic sck_w = sck_oe ? sck_o : m_sck;
  wire logic ws_w = ws_oe ? ws_o : m_ws;
  wire logic [2:0] pins = {ws_o, sck_o, osc};
  aiu_row_type rows [12] = '{
    '{1'b0, AIU_CFG_OFS, 32'h6, AIU_RESP_OK}, '{1'b0, AIU_OSC_OFS, 32'h0, AIU_RESP_OK},
    '{1'b0, AIU_DIV_OFS, 32'h8, AIU_RESP_OK}, '{1'b0, AIU_HALF_OFS, 32'h20, AIU_RESP_OK},
    '{1'b1, AIU_DIV_OFS, 32'h0, AIU_RESP_OK}, '{1'b0, AIU_DIV_OFS, 32'h0, AIU_RESP_OK},
    '{1'b1, AIU_HALF_OFS, 32'h0, AIU_RESP_OK}, '{1'b0, AIU_HALF_OFS, 32'h0, AIU_RESP_OK},
    '{1'b1, AIU_STAT_OFS, 32'h1, AIU_RESP_ERR}, '{1'b0, 8'h1c, 32'h0, AIU_RESP_ERR},
    '{1'b1, 8'h40, 32'hff, AIU_RESP_ERR}, '{1'b0, AIU_LEFT_OFS, 32'h0, AIU_RESP_OK}};
  always #12.5 aclk = ~aclk;
  aiu_rx aiu_rx_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .oversample_clock_out(osc), .serial_bit_clock_i(sck_w),
    .serial_bit_clock_o(sck_o), .serial_bit_clock_oe(sck_oe), .serial_data_in(sd),
    .word_select_line_i(ws_w), .word_select_line_o(ws_o), .word_select_line_oe(ws_oe),
    .frame_out(frame_out), .frame_valid(frame_valid));
  aiu_conv_model aiu_conv_model_inst (.sck_w(sck_w), .rise(m_rise), .run(m_run),
    .half_ns(m_half), .left(m_left), .right(m_right), .own_sck(m_sck), .own_ws(m_ws), .sd(sd));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r = 2'bxx;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    chk("bresp", {62'h0, er}, {62'h0, r});
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [33:0] g = 34'hx;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        g = {rresp, rdata};
        rready <= 1'b0;
        break;
      end
    end
    chk("rdata", {30'h0, er, ed}, {30'h0, g});
  endtask
  task automatic wait_frames(input int n);
    int k = 0;
    for (int i = 0; i < 20000 && k < n; i++)
    begin
      @(posedge aclk);
      if (frame_valid === 1'b1) k++;
    end
    chk("frames", 64'(n), 64'(k));
  endtask
  // cycles between two rising edges of one output pin
  task automatic period(input int s, input int e);
    logic p;
    int t0;
    int d;
    p = pins[s];
    t0 = -1;
    d = -1;
    for (int i = 0; i < 3000 && d < 0; i++)
    begin
      @(posedge aclk);
      if (pins[s] && !p)
      begin
        if (t0 >= 0) d = i - t0;
        else t0 = i;
      end
      p = pins[s];
    end
    chk("period", 64'(e), 64'(d));
  endtask
  task automatic results();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #500_000;
    n_errors++;
    results();
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
      if (rows[i].we) reg_wr(rows[i].a, rows[i].d, rows[i].r);
      else reg_rd(rows[i].a, rows[i].d, rows[i].r);
    // slave role, rising edge sampling, converter clock at 110 ns phases
    m_left <= 32'hc3a5_0f81; m_right <= 32'h1e6b_d247; m_run <= 1'b1;
    wait_frames(2);
    chk("frame", 64'hc3a5_0f81_1e6b_d247, frame_out);
    chk("sck_oe", 64'h0, {63'h0, sck_oe});
    reg_rd(AIU_RIGHT_OFS, 32'h1e6b_d247, AIU_RESP_OK);
    // falling edge sampling at another bit rate, boundary words
    reg_wr(AIU_CFG_OFS, 32'h4, AIU_RESP_OK);
    m_rise <= 1'b0; m_half <= 160; m_left <= 32'h8000_0001; m_right <= 32'h7fff_fffe;
    wait_frames(2);
    chk("frame", 64'h8000_0001_7fff_fffe, frame_out);
    // master role: 10 MHz oversampling clock, zero divisor clamped to two, 32-bit halves
    m_run <= 1'b0; m_rise <= 1'b1; m_left <= 32'hffff_ffff; m_right <= 32'hffff_ffff;
    reg_wr(AIU_OSC_OFS, 32'h4000_0000, AIU_RESP_OK);
    reg_wr(AIU_DIV_OFS, 32'h0, AIU_RESP_OK);
    reg_wr(AIU_HALF_OFS, 32'h20, AIU_RESP_OK);
    reg_wr(AIU_CFG_OFS, 32'h7, AIU_RESP_OK);
    chk("sck_oe", 64'h1, {63'h0, sck_oe & ws_oe});
    period(0, 4);
    period(1, 8);
    period(2, 512);
    wait_frames(2);
    chk("frame", 64'hffff_ffff_ffff_ffff, frame_out);
    // second reset in mid-run returns to the slave default
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    reg_rd(AIU_CFG_OFS, 32'h6, AIU_RESP_OK);
    chk("sck_oe", 64'h0, {63'h0, sck_oe});
    results();
  end
endmodule // testbench
`default_nettype wire
